// ### common/afi_pkg.sv
/*
 * constants and carrier types for the accelerometer feature-control and
 * start-up key register bank.
 * assumes a register access port driven by the serial interface logic.
 */
package afi_pkg;
  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h09;
  localparam logic [7:0] ADDR_FEATURE_ONE  = 8'h0d;
  localparam logic [7:0] ADDR_FEATURE_TWO  = 8'h0e;
  localparam logic [7:0] ADDR_STARTUP_KEY  = 8'h0f;
  // ****************************************************************
  // feature_control_two bit positions
  // ****************************************************************
  localparam int BIT_TRIG_ENABLE   = 7;
  localparam int BIT_TRIG_EDGE     = 6;
  localparam int BIT_STREAM        = 5;
  localparam int BIT_WRITE_CLEARS  = 4;
  localparam int BIT_BUF_TOKEN     = 3;
  localparam int BIT_SPI_TOKEN     = 2;
  localparam int BIT_BURST         = 1;
  localparam int BIT_WRAP          = 0;
  // feature_control_one interface select bits
  localparam int BIT_SPI_SELECT    = 7;
  localparam int BIT_I2C_SELECT    = 6;
  localparam int BIT_SPI3_SELECT   = 5;
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  // ****************************************************************
  // start-up key values
  // ****************************************************************
  localparam logic [7:0] KEY_STARTING  = 8'h45;
  localparam logic [7:0] KEY_READY     = 8'h40;
  localparam logic [7:0] KEY_WRITE     = 8'h42;
  localparam logic [7:0] KEY_DONE      = 8'h43;
  // start-up time, cycles at 20 MHz
  localparam int STARTUP_NS       = 1000;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int STARTUP_CYCLES   = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES_TOKEN_LIMIT  = 14;

  typedef enum logic [1:0] {
    KEY_ST_START = 2'b00,
    KEY_ST_READY = 2'b01,
    KEY_ST_DONE  = 2'b10
  } afi_key_state_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       isI2c;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afi_reg_req_t;

  typedef struct packed {
    logic irqWaiting;
    logic bufferLevel;
    logic bufferFull;
    logic bufferEmpty;
  } afi_buf_flags_t;
endpackage

// ### design/afi_feature_regs.sv
/*
 * feature-control two, start-up key register, token insertion,
 * interrupt clearing, stream-mode decision and outside trigger.
 * assumes a one-cycle register request from the serial interface logic
 * and buffer flags from the sample buffer, all on core_clk.
 */
`timescale 1ns/100ps
module afi_feature_regs #(
  parameter int STARTUP_COUNT = afi_pkg::STARTUP_CYCLES,
  parameter int RES_BITS_W    = 5
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  // register access
  input  wire afi_pkg::afi_reg_req_t  regReq,
  output logic [7:0]                  regRdata,
  output logic                        regAccepted,
  // interface select from feature_control_one
  input  wire logic [7:0]             featureOne,
  // spi status token
  input  wire logic                   spiFirstByte,
  input  wire logic [7:0]             systemStatus,
  output logic [7:0]                  spiTokenByte,
  output logic                        spiTokenValid,
  // buffer token and stream
  input  wire logic [RES_BITS_W-1:0]  resolutionBits,
  input  wire logic [15:0]            zWordIn,
  input  wire afi_pkg::afi_buf_flags_t bufFlags,
  input  wire logic                   bufferEnable,
  input  wire logic                   sampleArrives,
  output logic [15:0]                 zWordOut,
  output logic                        dropOldest,
  output logic                        sampleAccept,
  // interrupts
  input  wire logic                   irqPendingIn,
  output logic                        irqClear,
  // interrupt pin
  input  wire logic                   interrupt_out_pin_in,
  output logic                        interrupt_out_pin_out,
  output logic                        interrupt_out_pin_oe,
  output logic                        outsideTrigger,
  // decoded controls
  output logic [7:0]                  featureTwo
);
  // ****************************************************************
  // feature_control_two and key state
  // ****************************************************************
  logic [7:0]              feature_control_two;
  afi_pkg::afi_key_state_t keyState;
  logic [15:0]             startCount;
  logic                    spiChosen;
  logic                    i2cChosen;
  logic                    accessOk;
  logic                    triggerPulse;
  logic                    hitIrq;
  logic                    readClears;

  assign i2cChosen = featureOne[afi_pkg::BIT_I2C_SELECT];
  assign spiChosen = featureOne[afi_pkg::BIT_SPI_SELECT] | featureOne[afi_pkg::BIT_SPI3_SELECT];
  // selecting one interface shuts the other out
  assign accessOk  = regReq.valid &
                     (regReq.isI2c ? ~spiChosen : ~i2cChosen);
  assign hitIrq    = accessOk & (regReq.addr == afi_pkg::ADDR_IRQ_STATUS);
  // write-clear only counts with I2C selected; SPI reads never clear
  assign readClears = regReq.isI2c &
                      ~(feature_control_two[afi_pkg::BIT_WRITE_CLEARS] & i2cChosen);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      feature_control_two <= afi_pkg::FEATURE_RESET;
    end else if (accessOk && regReq.write && regReq.addr == afi_pkg::ADDR_FEATURE_TWO) begin
      feature_control_two <= regReq.wdata;
    end
  end

  // ****************************************************************
  // start-up key sequence
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      keyState   <= afi_pkg::KEY_ST_START;
      startCount <= 16'h0000;
    end else begin
      case (keyState)
        afi_pkg::KEY_ST_START: begin
          if (startCount == 16'(STARTUP_COUNT - 1)) begin
            keyState <= afi_pkg::KEY_ST_READY;
          end else begin
            startCount <= startCount + 16'h0001;
          end
        end
        afi_pkg::KEY_ST_READY: begin
          if (accessOk && regReq.write && regReq.addr == afi_pkg::ADDR_STARTUP_KEY &&
              regReq.wdata == afi_pkg::KEY_WRITE) begin
            keyState <= afi_pkg::KEY_ST_DONE;
          end
        end
        afi_pkg::KEY_ST_DONE: keyState <= afi_pkg::KEY_ST_DONE;
        default: keyState <= afi_pkg::KEY_ST_START;
      endcase
    end
  end

  // ****************************************************************
  // read data and interrupt clearing
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata    <= 8'h00;
      regAccepted <= 1'b0;
      irqClear    <= 1'b0;
    end else begin
      regAccepted <= accessOk;
      irqClear    <= hitIrq & (regReq.write ? 1'b1 : readClears);
      if (accessOk && !regReq.write) begin
        case (regReq.addr)
          afi_pkg::ADDR_FEATURE_TWO: regRdata <= feature_control_two;
          afi_pkg::ADDR_STARTUP_KEY: begin
            case (keyState)
              afi_pkg::KEY_ST_START: regRdata <= afi_pkg::KEY_STARTING;
              afi_pkg::KEY_ST_READY: regRdata <= afi_pkg::KEY_READY;
              default:               regRdata <= afi_pkg::KEY_DONE;
            endcase
          end
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // status tokens
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      spiTokenByte  <= 8'h00;
      spiTokenValid <= 1'b0;
    end else begin
      // 4-wire only: 3-wire and I2C never carry the token
      spiTokenValid <= spiFirstByte & feature_control_two[afi_pkg::BIT_SPI_TOKEN] &
                       featureOne[afi_pkg::BIT_SPI_SELECT] &
                       ~featureOne[afi_pkg::BIT_SPI3_SELECT];
      spiTokenByte  <= systemStatus;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      zWordOut <= 16'h0000;
    end else if (!feature_control_two[afi_pkg::BIT_BUF_TOKEN]) begin
      zWordOut <= zWordIn;
    end else if (resolutionBits < RES_BITS_W'(afi_pkg::RES_TOKEN_LIMIT)) begin
      zWordOut <= {bufFlags, zWordIn[11:0]};
    end else begin
      zWordOut <= {zWordIn[15:4], bufFlags};
    end
  end

  // ****************************************************************
  // stream mode
  // ****************************************************************
  // full buffer without stream refuses samples rather than overwriting
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dropOldest   <= 1'b0;
      sampleAccept <= 1'b0;
    end else begin
      dropOldest   <= sampleArrives & bufferEnable & bufFlags.bufferFull &
                      feature_control_two[afi_pkg::BIT_STREAM];
      sampleAccept <= sampleArrives & bufferEnable &
                      (~bufFlags.bufferFull | feature_control_two[afi_pkg::BIT_STREAM]);
    end
  end

  // ****************************************************************
  // outside trigger and interrupt pin
  // ****************************************************************
  afi_trigger_sync u_trig (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .edgeSelect   (feature_control_two[afi_pkg::BIT_TRIG_EDGE]),
    .pinIn        (interrupt_out_pin_in),
    .triggerPulse (triggerPulse)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outsideTrigger        <= 1'b0;
      interrupt_out_pin_oe  <= 1'b0;
      interrupt_out_pin_out <= 1'b1;
      featureTwo            <= afi_pkg::FEATURE_RESET;
    end else begin
      outsideTrigger        <= triggerPulse &
                               feature_control_two[afi_pkg::BIT_TRIG_ENABLE];
      // active-low open drain: drive only while an interrupt waits
      interrupt_out_pin_oe  <= ~feature_control_two[afi_pkg::BIT_TRIG_ENABLE] &
                               irqPendingIn;
      interrupt_out_pin_out <= 1'b0;
      featureTwo            <= feature_control_two;
    end
  end
endmodule // afi_feature_regs

// ### design/afi_trigger_sync.sv
/*
 * two-stage synchroniser and edge picker for the outside trigger pin.
 * assumes the pin is asynchronous to core_clk.
 */
`timescale 1ns/100ps
module afi_trigger_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // control
  input  wire logic edgeSelect,
  // pin and result
  input  wire logic pinIn,
  output logic      triggerPulse
);
  logic syncOne;
  logic syncTwo;
  logic syncLast;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncOne  <= 1'b1;
      syncTwo  <= 1'b1;
      syncLast <= 1'b1;
    end else begin
      syncOne  <= pinIn;
      syncTwo  <= syncOne;
      syncLast <= syncTwo;
    end
  end

  // one pulse per selected edge: compare synced sample to its previous copy
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      triggerPulse <= 1'b0;
    end else begin
      triggerPulse <= edgeSelect ? (syncTwo & ~syncLast)
                                 : (~syncTwo & syncLast);
    end
  end
endmodule // afi_trigger_sync

// ### verification/afi_feature_monitor.sv
/* checker bound onto the feature register bank; sees only its ports.
   assumes answers register one cycle after the request edge. */
`timescale 1ns/100ps
module afi_feature_monitor #(
  parameter int STARTUP_COUNT = 20,
  parameter int RES_BITS_W    = 5
) (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    reset_n,
  // register side
  input wire afi_pkg::afi_reg_req_t   regReq,
  input wire logic [7:0]              featureOne,
  input wire logic [7:0]              featureTwo,
  input wire logic                    irqClear,
  // buffer token and stream
  input wire logic [RES_BITS_W-1:0]   resolutionBits,
  input wire logic [15:0]             zWordIn,
  input wire afi_pkg::afi_buf_flags_t bufFlags,
  input wire logic                    bufferEnable,
  input wire logic                    sampleArrives,
  input wire logic [15:0]             zWordOut,
  input wire logic                    dropOldest,
  input wire logic                    sampleAccept,
  // trigger pin
  input wire logic                    interrupt_out_pin_in,
  input wire logic                    interrupt_out_pin_oe,
  input wire logic                    outsideTrigger
);
  // ************************************************************
  // properties
  // ************************************************************
  // shut-out requests are left out: they may do nothing at all
  wire logic opened = regReq.isI2c ? !(featureOne[7] || featureOne[5]) : !featureOne[6];
  wire logic wr9    = regReq.valid && regReq.write && regReq.addr == 8'h09 && opened;
  wire logic rd9    = regReq.valid && !regReq.write && regReq.addr == 8'h09 && opened;
  // featureTwo trails the register by one cycle: read it one cycle late
  wire logic fullIn = sampleArrives && bufFlags.bufferFull;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rise; featureTwo[7] && featureTwo[6] && $rose(interrupt_out_pin_in); endsequence
  sequence s_fall; featureTwo[7] && !featureTwo[6] && $fell(interrupt_out_pin_in); endsequence
  a_write_clears: assert property (wr9 |=> irqClear)
    else $error("write gave no clear");
  a_read_clears: assert property ((rd9 && regReq.isI2c) ##1
    !(featureTwo[4] && $past(featureOne[6])) |-> irqClear) else $error("read gave no clear");
  a_read_keeps: assert property (rd9 ##1
    (!$past(regReq.isI2c) || (featureTwo[4] && $past(featureOne[6]))) |-> !irqClear)
    else $error("read cleared");
  a_token_low: assert property ((resolutionBits < 14) ##1 featureTwo[3] |->
    zWordOut == {$past(bufFlags), $past(zWordIn[11:0])}) else $error("low token");
  a_token_high: assert property ((resolutionBits >= 14) ##1 featureTwo[3] |->
    zWordOut == {$past(zWordIn[15:4]), $past(bufFlags)}) else $error("high token");
  a_token_off: assert property (1'b1 ##1 !featureTwo[3] |-> zWordOut == $past(zWordIn))
    else $error("z word altered");
  a_stream_drop: assert property ((fullIn && bufferEnable) ##1 featureTwo[5] |->
    dropOldest && sampleAccept) else $error("no drop in stream");
  a_full_stops: assert property (fullIn ##1 !($past(bufferEnable) && featureTwo[5]) |->
    !sampleAccept && !dropOldest) else $error("full buffer took sample");
  a_edge_trigger: assert property ((s_rise or s_fall) |-> ##[1:6] outsideTrigger)
    else $error("edge lost");
  a_one_pulse: assert property (outsideTrigger |=> !outsideTrigger)
    else $error("trigger too long");
  a_pin_input: assert property (featureTwo[7] && $past(featureTwo[7]) |-> !interrupt_out_pin_oe)
    else $error("pin driven");
endmodule // afi_feature_monitor
bind afi_feature_regs afi_feature_monitor #(
  .STARTUP_COUNT(STARTUP_COUNT), .RES_BITS_W(RES_BITS_W)) mon (.core_clk, .reset_n, .regReq,
  .featureOne, .featureTwo, .irqClear, .resolutionBits, .zWordIn, .bufFlags, .bufferEnable,
  .sampleArrives, .zWordOut, .dropOldest, .sampleAccept, .interrupt_out_pin_in,
  .interrupt_out_pin_oe, .outsideTrigger);

// ### verification/afi_feature_regs_tb.sv
/* self-checking bench for the feature register bank and its host model.
   assumes a 20 MHz clock and a pulled-up open-drain trigger pin. */
`timescale 1ns/100ps
module afi_feature_regs_tb;
  typedef struct packed {logic [7:0] f; logic [4:0] r; logic [15:0] z;} afi_row_t;
  logic                    core_clk = 1'b0, reset_n = 1'b0, spiFirstByte = 1'b0;
  logic                    bufferEnable = 1'b0, sampleArrives = 1'b0, irqPendingIn = 1'b1;
  logic                    pinDrv = 1'b1, pinOut, pinOe, outsideTrigger, irqClear, regAccepted;
  logic                    spiTokenValid, dropOldest, sampleAccept;
  logic [7:0]              featureOne = 8'h40, systemStatus = 8'h5a;
  logic [7:0]              regRdata, spiTokenByte, featureTwo;
  logic [4:0]              resolutionBits = 5'h0c;
  logic [15:0]             zWordIn = 16'habcd, zWordOut, trigCount = 16'h0;
  int                      failures = 0, total_checks = 0, cycles = 0;
  afi_pkg::afi_buf_flags_t bufFlags = 4'h6;
  afi_pkg::afi_reg_req_t   regReq;
  wire logic               pinWire = pinOe ? pinOut : pinDrv;
  afi_row_t                rows [4] = '{'{8'h00, 5'h0c, 16'habcd}, '{8'h08, 5'h0c, 16'h6bcd},
                                        '{8'h08, 5'h0d, 16'h6bcd}, '{8'h08, 5'h0e, 16'habc6}};
  afi_feature_regs #(.STARTUP_COUNT(6)) uut (.core_clk, .reset_n, .regReq, .regRdata,
    .regAccepted, .featureOne, .spiFirstByte, .systemStatus, .spiTokenByte, .spiTokenValid,
    .resolutionBits, .zWordIn, .bufFlags, .bufferEnable, .sampleArrives, .zWordOut,
    .dropOldest, .sampleAccept, .irqPendingIn, .irqClear, .interrupt_out_pin_in(pinWire),
    .interrupt_out_pin_out(pinOut), .interrupt_out_pin_oe(pinOe), .outsideTrigger, .featureTwo);
  afi_host_model host (.core_clk, .regReq, .regRdata, .regAccepted, .irqClear);
  always #25 core_clk = ~core_clk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    trigCount <= trigCount + 16'(outsideTrigger);
    if (cycles == 3000) begin
      failures++;
      results();
    end
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] exp, got);
    total_checks++;
    if (exp !== got) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ft2(input logic [7:0] v);
    host.io(1'b1, !featureOne[7], 8'h0e, v);
  endtask
  task automatic key(input logic [7:0] exp);
    host.io(1'b0, 1'b1, 8'h0f, 8'h00);
    chk("startupKey", 16'(exp), 16'(host.rd));
  endtask
  task automatic clr9(input logic w, exp);
    host.io(w, !featureOne[7], 8'h09, 8'ha5);
    chk("irqClear", 16'(exp), 16'(host.clr));
  endtask
  task automatic tok(input logic exp);
    spiFirstByte = 1'b1;
    @(negedge core_clk);
    spiFirstByte = 1'b0;
    chk("spiTokenValid", 16'(exp), 16'(spiTokenValid));
    if (exp)
      chk("spiTokenByte", 16'h5a, 16'(spiTokenByte));
  endtask
  task automatic strm(input logic [7:0] f, input logic en, exp);
    ft2(f);
    bufferEnable = en;
    sampleArrives = 1'b1;
    @(negedge core_clk);
    sampleArrives = 1'b0;
    chk("dropOldest", 16'(exp), 16'(dropOldest));
    chk("sampleAccept", 16'(exp), 16'(sampleAccept));
  endtask
  // trigger pin square wave of 400 ns, off the core clock phase: 8 rising and 8 falling edges
  task automatic trig();
    logic [15:0] base;
    base = trigCount;
    repeat (16) begin
      repeat (4) @(negedge core_clk);
      #7 pinDrv = ~pinDrv;
    end
    repeat (8) @(negedge core_clk);
    chk("triggers", 16'h8, trigCount - base);
  endtask
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      ft2(rows[i].f);
      resolutionBits = rows[i].r;
      repeat (2) @(negedge core_clk);
      chk("zWordOut", rows[i].z, zWordOut);
    end
    reset_n = 1'b0;
    @(negedge core_clk);
    reset_n = 1'b1;
    chk("featureTwo", 16'h0, 16'(featureTwo));
    key(8'h45);
    repeat (8) @(negedge core_clk);
    key(8'h40);
    host.unlock();
    key(8'h43);
    host.io(1'b0, 1'b1, 8'h20, 8'h00);
    chk("unmapped", 16'h0, 16'(host.rd));
    clr9(1'b0, 1'b1);
    ft2(8'h10);
    clr9(1'b0, 1'b0);
    clr9(1'b1, 1'b1);
    featureOne = 8'h00;
    clr9(1'b0, 1'b1);
    featureOne = 8'h80;
    clr9(1'b0, 1'b0);
    clr9(1'b1, 1'b1);
    host.io(1'b1, 1'b1, 8'h0e, 8'h00);
    chk("regAccepted", 16'h0, 16'(host.acc));
    ft2(8'h14);
    tok(1'b1);
    featureOne = 8'ha0;
    tok(1'b0);
    featureOne = 8'h40;
    tok(1'b0);
    strm(8'h20, 1'b1, 1'b1);
    strm(8'h20, 1'b0, 1'b0);
    strm(8'h00, 1'b1, 1'b0);
    chk("pinOe", 16'h1, 16'(pinOe));
    chk("pinOut", 16'h0, 16'(pinOut));
    ft2(8'hc0);
    repeat (8) @(negedge core_clk);
    chk("pinOe", 16'h0, 16'(pinOe));
    trig();
    ft2(8'h80);
    trig();
    results();
  end
endmodule // afi_feature_regs_tb

// ### verification/afi_host_model.sv
/* host model: one-cycle register requests launched from the falling edge.
   assumes the bank answers on the rising edge that takes the request. */
`timescale 1ns/100ps
module afi_host_model (
  // clock
  input  wire logic             core_clk,
  // register port
  output afi_pkg::afi_reg_req_t regReq,
  input  wire logic [7:0]       regRdata,
  input  wire logic             regAccepted,
  input  wire logic             irqClear
);
  logic [7:0] rd;
  logic       acc;
  logic       clr;
  initial regReq = '0;
  // ************************************************************
  // bus cycle
  // ************************************************************
  // spi hosts clear by writing 0x09, a read never clears
  task automatic io(input logic w, i2c, input logic [7:0] a, d);
    @(negedge core_clk);
    regReq = {1'b1, w, i2c, a, d};
    @(negedge core_clk);
    regReq = '0;
    rd  = regRdata;
    acc = regAccepted;
    clr = irqClear;
  endtask
  // start-up key, written once start-up is over
  task automatic unlock();
    io(1'b1, 1'b1, 8'h0f, 8'h42);
  endtask
endmodule // afi_host_model
